// *** verilog/pidc_consts.vh ***
// Constants for the sampled PID loop controller
`ifndef PIDC_CONSTS_VH
`define PIDC_CONSTS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define PIDC_REG_STATUS 4'h0
`define PIDC_REG_MASK 4'h4
`define PIDC_REG_CTRL 4'h8
`define PIDC_REG_OUTPUT 4'hC

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define PIDC_ST_DONE 0
`define PIDC_ST_RANGE 1
`define PIDC_CTRL_BIPOLAR 0
`define PIDC_STATUS_RST 2'h0
`define PIDC_MASK_RST 2'h0
`define PIDC_CTRL_RST 1'h0

// ****************************************************************
// Arithmetic and timing
// ****************************************************************
`define PIDC_TICK_MS 100
`define PIDC_CLK_KHZ 100000
`define PIDC_PERCENT 8'h64
`define PIDC_DIV_LAST 6'h31
`define PIDC_OUT_MAX 13'h0FFF
`define PIDC_OUT_MIN 13'h1000

`endif

// *** verilog/pidc_udiv.v ***
// Sequential restoring divider, one quotient bit per cycle
`timescale 1ns/10ps
`include "pidc_consts.vh"
module pidc_udiv
(
  input wire core_clk,
  input wire rst_n,
  input wire abort,
  input wire start,
  input wire [49:0] dividend,
  input wire [23:0] divisor,
  output reg done,
  output reg [49:0] quotient
);

  reg [23:0] rem;
  reg [23:0] dvs;
  reg [49:0] quo;
  reg [5:0] cnt;
  reg run;
  wire [24:0] shifted;
  wire [24:0] diff;
  wire fits;
  wire [23:0] next_rem;
  wire [49:0] next_quo;

  assign shifted = {rem, quo[49]};
  assign diff = shifted - {1'b0, dvs};
  assign fits = (shifted >= {1'b0, dvs});
  assign next_rem = fits ? diff[23:0] : shifted[23:0];
  assign next_quo = {quo[48:0], fits};

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rem <= 24'h000000;
      dvs <= 24'h000000;
      quo <= 50'h0;
      cnt <= 6'h00;
      run <= 1'b0;
      done <= 1'b0;
      quotient <= 50'h0;
    end
    else
    begin
      done <= 1'b0;
      if (abort)
      begin
        run <= 1'b0;
      end
      else if (start)
      begin
        if (divisor == 24'h000000)
        begin
          quotient <= 50'h0;
          done <= 1'b1;
          run <= 1'b0;
        end
        else
        begin
          quo <= dividend;
          dvs <= divisor;
          rem <= 24'h000000;
          cnt <= `PIDC_DIV_LAST;
          run <= 1'b1;
        end
      end
      else if (run)
      begin
        rem <= next_rem;
        quo <= next_quo;
        cnt <= cnt - 6'h01;
        if (cnt == 6'h00)
        begin
          run <= 1'b0;
          done <= 1'b1;
          quotient <= next_quo;
        end
      end
    end
  end

endmodule // pidc_udiv

// *** verilog/pidc_scan_timer.v ***
// Scan interval timer with 100 ms base tick
`timescale 1ns/10ps
`include "pidc_consts.vh"
module pidc_scan_timer
#(
  parameter TICK_CYCLES = `PIDC_TICK_MS * `PIDC_CLK_KHZ
)
(
  input wire core_clk,
  input wire rst_n,
  input wire enable,
  input wire [15:0] interval,
  input wire calc_idle,
  output wire scan_go
);

  localparam [23:0] TICK_LAST = TICK_CYCLES[23:0] - 24'h000001;

  reg [23:0] pre_cnt;
  reg [15:0] ivl_cnt;
  reg due;
  wire tick;
  wire elapsed;
  wire [16:0] ivl_inc;

  assign tick = (pre_cnt == TICK_LAST);
  assign ivl_inc = {1'b0, ivl_cnt} + 17'h00001;
  assign elapsed = tick && (interval != 16'h0000)
    && (ivl_inc >= {1'b0, interval});
  // Zero interval fires whenever the previous calculation is finished
  assign scan_go = enable && calc_idle
    && ((interval == 16'h0000) || due);

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_cnt <= 24'h000000;
      ivl_cnt <= 16'h0000;
      due <= 1'b0;
    end
    else if (!enable)
    begin
      pre_cnt <= 24'h000000;
      ivl_cnt <= 16'h0000;
      due <= 1'b0;
    end
    else
    begin
      pre_cnt <= tick ? 24'h000000 : pre_cnt + 24'h000001;
      if (elapsed)
      begin
        ivl_cnt <= 16'h0000;
      end
      else if (tick)
      begin
        ivl_cnt <= ivl_inc[15:0];
      end
      if (scan_go)
      begin
        due <= 1'b0;
      end
      if (elapsed)
      begin
        due <= 1'b1;
      end
    end
  end

endmodule // pidc_scan_timer

// *** verilog/pidc_top.v ***
// Sampled PID loop controller with register port and interrupt
`timescale 1ns/10ps
`include "pidc_consts.vh"
module pidc_top
#(
  parameter TICK_CYCLES = `PIDC_TICK_MS * `PIDC_CLK_KHZ
)
(
  input wire core_clk,
  input wire rst_n,
  input wire master_enable,
  input wire prop_term_enable,
  input wire integ_term_enable,
  input wire deriv_term_enable,
  input wire manual_select,
  input wire [15:0] setpoint_in,
  input wire [15:0] actual_in,
  input wire [15:0] gain_percent,
  input wire [15:0] reset_time,
  input wire [15:0] rate_time,
  input wire [15:0] scan_interval,
  input wire [12:0] manual_value,
  input wire [3:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [12:0] control_output,
  output reg range_exceeded,
  output reg [15:0] reg_rdata,
  output wire irq
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_P = 3'h1;
  localparam [2:0] S_I = 3'h2;
  localparam [2:0] S_D = 3'h3;
  localparam [2:0] S_OUT = 3'h4;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg [2:0] state;
  reg div_start;
  reg first_scan;
  reg [15:0] prev_actual;
  reg signed [16:0] err;
  reg signed [16:0] dact;
  reg [15:0] kp_s;
  reg [15:0] tn_s;
  reg [15:0] tv_s;
  reg [15:0] tc_s;
  reg en_p;
  reg en_i;
  reg en_d;
  reg signed [47:0] p_term;
  reg signed [47:0] i_acc;
  reg signed [47:0] d_term;
  reg [12:0] alg_out;
  reg [1:0] status;
  reg [1:0] mask;
  reg bipolar_mode;
  reg [49:0] div_num;
  reg [23:0] div_den;
  reg [12:0] next_out;
  reg next_range;
  wire unipolar_mode;
  wire scan_go;
  wire div_done;
  wire [49:0] div_q;
  wire signed [16:0] err_now;
  wire signed [16:0] dact_now;
  wire [16:0] mag_e;
  wire [16:0] mag_d;
  wire [32:0] prod_p;
  wire [48:0] prod_i;
  wire [48:0] prod_d;
  wire [23:0] den_i;
  wire [23:0] den_d;
  wire signed [47:0] q_signed_e;
  wire signed [47:0] q_signed_d;
  wire signed [49:0] sum;
  wire over;
  wire under;
  wire ev_done;
  wire ev_range;
  wire [1:0] clr_bits;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [16:0] pidc_abs;
    input [16:0] v;
    begin
      pidc_abs = v[16] ? (~v + 17'h00001) : v;
    end
  endfunction

  function [47:0] pidc_apply_sign;
    input neg;
    input [46:0] mag;
    begin
      pidc_apply_sign = neg ? (~{1'b0, mag} + 48'h1) : {1'b0, mag};
    end
  endfunction

  // ****************************************************************
  // Scan timing
  // ****************************************************************
  pidc_scan_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .enable(master_enable),
    .interval(scan_interval),
    .calc_idle(state == S_IDLE),
    .scan_go(scan_go)
  );

  // ****************************************************************
  // Arithmetic
  // ****************************************************************
  // Inputs are signed 16-bit, widened so the difference cannot wrap
  assign err_now = $signed({setpoint_in[15], setpoint_in})
    - $signed({actual_in[15], actual_in});
  assign dact_now = first_scan ? 17'h00000 :
    $signed({prev_actual[15], prev_actual})
    - $signed({actual_in[15], actual_in});
  assign mag_e = pidc_abs(err);
  assign mag_d = pidc_abs(dact);
  assign prod_p = kp_s * mag_e;
  assign prod_i = kp_s * tc_s * mag_e;
  assign prod_d = kp_s * tv_s * mag_d;
  // Gain is percent, so every divisor carries the factor 100
  assign den_i = tn_s * `PIDC_PERCENT;
  assign den_d = tc_s * `PIDC_PERCENT;
  assign q_signed_e = pidc_apply_sign(err[16], div_q[46:0]);
  assign q_signed_d = pidc_apply_sign(dact[16], div_q[46:0]);

  always @*
  begin
    div_num = 50'h0;
    div_den = 24'h000000;
    case (state)
      S_P:
      begin
        div_num = {17'h00000, prod_p};
        div_den = {16'h0000, `PIDC_PERCENT};
      end
      S_I:
      begin
        div_num = {1'b0, prod_i};
        div_den = den_i;
      end
      S_D:
      begin
        div_num = {1'b0, prod_d};
        div_den = den_d;
      end
      default:
      begin
        div_num = 50'h0;
        div_den = 24'h000000;
      end
    endcase
  end

  pidc_udiv u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .abort(!master_enable),
    .start(div_start),
    .dividend(div_num),
    .divisor(div_den),
    .done(div_done),
    .quotient(div_q)
  );

  // ****************************************************************
  // Output range
  // ****************************************************************
  assign unipolar_mode = !bipolar_mode;
  assign sum = {{2{p_term[47]}}, p_term} + {{2{i_acc[47]}}, i_acc}
    + {{2{d_term[47]}}, d_term};
  assign over = (sum > $signed({37'h0, `PIDC_OUT_MAX}));
  assign under = unipolar_mode ? sum[49] :
    (sum < $signed({{37{1'b1}}, `PIDC_OUT_MIN}));

  always @*
  begin
    next_out = sum[12:0];
    next_range = over || under;
    if (over)
    begin
      next_out = `PIDC_OUT_MAX;
    end
    else if (under)
    begin
      next_out = unipolar_mode ? 13'h0000 : `PIDC_OUT_MIN;
    end
  end

  // ****************************************************************
  // Calculation sequence
  // ****************************************************************
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= S_IDLE;
      div_start <= 1'b0;
      first_scan <= 1'b1;
      prev_actual <= 16'h0000;
      err <= 17'h00000;
      dact <= 17'h00000;
      kp_s <= 16'h0000;
      tn_s <= 16'h0000;
      tv_s <= 16'h0000;
      tc_s <= 16'h0000;
      en_p <= 1'b0;
      en_i <= 1'b0;
      en_d <= 1'b0;
      p_term <= 48'h0;
      i_acc <= 48'h0;
      d_term <= 48'h0;
      alg_out <= 13'h0000;
      range_exceeded <= 1'b0;
    end
    else if (!master_enable)
    begin
      state <= S_IDLE;
      div_start <= 1'b0;
      first_scan <= 1'b1;
      prev_actual <= 16'h0000;
      p_term <= 48'h0;
      i_acc <= 48'h0;
      d_term <= 48'h0;
      alg_out <= 13'h0000;
      range_exceeded <= 1'b0;
    end
    else
    begin
      div_start <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (scan_go)
          begin
            // Snapshot operands so the scan sees one consistent set
            err <= err_now;
            dact <= dact_now;
            prev_actual <= actual_in;
            first_scan <= 1'b0;
            kp_s <= gain_percent;
            tn_s <= reset_time;
            tv_s <= rate_time;
            tc_s <= scan_interval;
            en_p <= prop_term_enable;
            en_i <= integ_term_enable;
            en_d <= deriv_term_enable;
            div_start <= 1'b1;
            state <= S_P;
          end
        end
        S_P:
        begin
          if (div_done)
          begin
            p_term <= en_p ? q_signed_e : 48'h0;
            div_start <= 1'b1;
            state <= S_I;
          end
        end
        S_I:
        begin
          if (div_done)
          begin
            if (en_i)
            begin
              i_acc <= i_acc + q_signed_e;
            end
            else
            begin
              i_acc <= 48'h0;
            end
            div_start <= 1'b1;
            state <= S_D;
          end
        end
        S_D:
        begin
          if (div_done)
          begin
            d_term <= en_d ? q_signed_d : 48'h0;
            state <= S_OUT;
          end
        end
        S_OUT:
        begin
          alg_out <= next_out;
          range_exceeded <= next_range;
          state <= S_IDLE;
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Output selection
  // ****************************************************************
  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_output <= 13'h0000;
    end
    else if (!master_enable)
    begin
      control_output <= 13'h0000;
    end
    else if (manual_select)
    begin
      control_output <= manual_value;
    end
    else
    begin
      control_output <= alg_out;
    end
  end

  // ****************************************************************
  // Register port and interrupt
  // ****************************************************************
  assign ev_done = (state == S_OUT);
  assign ev_range = (state == S_OUT) && next_range;
  assign clr_bits = (reg_wr && reg_addr == `PIDC_REG_STATUS) ?
    reg_wdata[1:0] : 2'h0;
  assign irq = |(status & mask);

  always @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status <= `PIDC_STATUS_RST;
      mask <= `PIDC_MASK_RST;
      bipolar_mode <= `PIDC_CTRL_RST;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      // A new event in the clearing cycle keeps its bit set
      status <= (status & ~clr_bits) | {ev_range, ev_done};
      if (reg_wr && reg_addr == `PIDC_REG_MASK)
      begin
        mask <= reg_wdata[1:0];
      end
      if (reg_wr && reg_addr == `PIDC_REG_CTRL)
      begin
        bipolar_mode <= reg_wdata[`PIDC_CTRL_BIPOLAR];
      end
      reg_rdata <= 16'h0000;
      if (reg_rd)
      begin
        case (reg_addr)
          `PIDC_REG_STATUS: reg_rdata <= {14'h0000, status};
          `PIDC_REG_MASK: reg_rdata <= {14'h0000, mask};
          `PIDC_REG_CTRL: reg_rdata <= {15'h0000, bipolar_mode};
          `PIDC_REG_OUTPUT:
            reg_rdata <= {{3{control_output[12]}}, control_output};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule // pidc_top

// *** sim/pidc_chk.sv ***
// Port checker for the PID loop controller
`timescale 1ns/10ps
module pidc_chk
(
  input wire core_clk,
  input wire rst_n,
  input wire master_enable,
  input wire manual_select,
  input wire [12:0] manual_value,
  input wire [3:0] reg_addr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire [12:0] control_output,
  input wire range_exceeded
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Assertions
  // ****************************************
  property p_off_zero;
    !master_enable |=> control_output == 13'h0;
  endproperty
  a_off_zero: assert property (p_off_zero)
    else $error("output not cleared while disabled");
  property p_off_flag;
    !master_enable |=> !range_exceeded;
  endproperty
  a_off_flag: assert property (p_off_flag)
    else $error("flag not cleared while disabled");
  sequence s_start;
    $rose(master_enable) ##0 (master_enable && !manual_select) [*8];
  endsequence
  property p_quiet;
    s_start |-> control_output == 13'h0;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("output moved before first scan");
  property p_manual;
    master_enable && manual_select |=> control_output == $past(manual_value);
  endproperty
  a_manual: assert property (p_manual)
    else $error("output not following manual value");
  property p_rose_lim;
    $rose(range_exceeded) && !manual_select |=> manual_select ||
      control_output inside {13'h0, 13'hFFF, 13'h1000};
  endproperty
  a_rose_lim: assert property (p_rose_lim)
    else $error("flag raised without clamped output");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_rd_out;
    reg_rd && reg_addr == 4'hC |=>
      $signed(reg_rdata) == $signed($past(control_output));
  endproperty
  a_rd_out: assert property (p_rd_out)
    else $error("output read back wrong");
  property p_rd_hole;
    reg_rd && !(reg_addr inside {4'h0, 4'h4, 4'h8, 4'hC}) |=> reg_rdata == 16'h0;
  endproperty
  a_rd_hole: assert property (p_rd_hole)
    else $error("unmapped read not zero");
  property p_rd_narrow;
    reg_rd && reg_addr inside {4'h0, 4'h4} |=> reg_rdata[15:2] == 14'h0;
  endproperty
  a_rd_narrow: assert property (p_rd_narrow)
    else $error("unused status bits set");
  c_manual: cover property (master_enable && manual_select);
  c_limit: cover property ($rose(range_exceeded));
  c_read: cover property (reg_rd && reg_addr == 4'hC);
endmodule // pidc_chk

// *** sim/pidc_ctrl_prog.sv ***
// Control program model driving the operands of the controller
`timescale 1ns/10ps
module pidc_ctrl_prog
(
  input wire core_clk,
  output reg master_enable,
  output reg prop_term_enable,
  output reg integ_term_enable,
  output reg deriv_term_enable,
  output reg manual_select,
  output reg [15:0] setpoint_in,
  output reg [15:0] actual_in,
  output reg [15:0] gain_percent,
  output reg [15:0] reset_time,
  output reg [15:0] rate_time,
  output reg [15:0] scan_interval,
  output reg [12:0] manual_value
);
  initial
  begin
    {master_enable, manual_select, manual_value} = 15'h0;
    {prop_term_enable, integ_term_enable, deriv_term_enable} = 3'h0;
    {setpoint_in, actual_in, gain_percent} = 48'h0;
    {reset_time, rate_time, scan_interval} = 48'h0;
  end
  // Operands change together just after an edge
  task put_ops(input [15:0] sp, act, kp, tn, tv, tc, input [2:0] en);
    @(posedge core_clk);
    setpoint_in <= sp;
    actual_in <= act;
    gain_percent <= kp;
    reset_time <= tn;
    rate_time <= tv;
    scan_interval <= tc;
    {prop_term_enable, integ_term_enable, deriv_term_enable} <= en;
  endtask
  task put_mode(input en, man, input [12:0] mv);
    @(posedge core_clk);
    master_enable <= en;
    manual_select <= man;
    manual_value <= mv;
  endtask
endmodule // pidc_ctrl_prog

// *** sim/test_pidc_top.sv ***
// Self-checking bench for the PID loop controller
`timescale 1ns/10ps
`include "pidc_consts.vh"
module test_pidc_top;
  typedef struct packed
  {
    logic [15:0] sp, act, kp, tn, tc;
    logic [2:0] fl;
    logic [12:0] ex;
    logic rg;
  } pidc_row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  wire master_enable, prop_term_enable, integ_term_enable, deriv_term_enable;
  wire manual_select, range_exceeded, irq;
  wire [15:0] setpoint_in, actual_in, gain_percent, reset_time, rate_time;
  wire [15:0] scan_interval, reg_rdata;
  wire [12:0] manual_value, control_output;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t0;
  // Flags: P enable, I enable, bipolar
  pidc_row_t rows [11] = '{
    '{16'h3E8, 16'h190, 16'h96, 16'h0, 16'h0, 3'h4, 13'h384, 1'h0},
    '{16'h0, 16'h1F4, 16'h64, 16'h0, 16'h0, 3'h4, 13'h0, 1'h1},
    '{16'h0, 16'h1F4, 16'h64, 16'h0, 16'h0, 3'h5, 13'h1E0C, 1'h0},
    '{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0, 16'h0, 3'h5, 13'hFFF, 1'h1},
    '{16'h8000, 16'h7FFF, 16'h5DC, 16'h0, 16'h0, 3'h5, 13'h1000, 1'h1},
    '{16'h1388, 16'h0, 16'h64, 16'h0, 16'h0, 3'h4, 13'hFFF, 1'h1},
    '{16'hA, 16'h0, 16'h5DC, 16'h0, 16'h0, 3'h4, 13'h96, 1'h0},
    '{16'h1E, 16'h0, 16'h3E8, 16'h2, 16'h1, 3'h2, 13'h96, 1'h0},
    '{16'h1E, 16'h0, 16'h3E8, 16'h0, 16'h1, 3'h2, 13'h0, 1'h0},
    '{16'h3E8, 16'h0, 16'h64, 16'h0, 16'h0, 3'h0, 13'h0, 1'h0},
    '{16'hFFF, 16'h0, 16'h64, 16'h0, 16'h0, 3'h5, 13'hFFF, 1'h0}};
  pidc_ctrl_prog i_pidc_ctrl_prog (.core_clk, .master_enable,
    .prop_term_enable, .integ_term_enable, .deriv_term_enable,
    .manual_select, .setpoint_in, .actual_in, .gain_percent, .reset_time,
    .rate_time, .scan_interval, .manual_value);
  pidc_top #(.TICK_CYCLES(10)) i_pidc_top (.core_clk, .rst_n,
    .master_enable, .prop_term_enable, .integ_term_enable,
    .deriv_term_enable, .manual_select, .setpoint_in, .actual_in,
    .gain_percent, .reset_time, .rate_time, .scan_interval, .manual_value,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .control_output,
    .range_exceeded, .reg_rdata, .irq);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  // ****************************************
  // Tasks
  // ****************************************
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task bad(input string m);
    fail_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task chk_out(input logic [12:0] e);
    samples_checked++;
    if (control_output !== e) bad("control output");
  endtask
  task chk_bit(input logic g, input logic e, input string m);
    samples_checked++;
    if (g !== e) bad(m);
  endtask
  task chk_word(input logic [15:0] e);
    samples_checked++;
    if (reg_rdata !== e) bad("read data");
  endtask
  task reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task reg_read(input logic [3:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
  endtask
  task close_out;
    $display("mismatches %0d, comparisons %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Waits for the scan-done interrupt, failing after 1000 cycles
  task wait_done;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 1000)
    begin
      tick(1);
      n++;
    end
    if (n == 1000)
    begin
      bad("no scan done");
      close_out;
    end
  endtask
  task scan(input logic [15:0] act, sp);
    i_pidc_ctrl_prog.put_ops(sp, act, 16'h64, 16'h1E, 16'h1E, 16'h1E, 3'h3);
    reg_write(`PIDC_REG_STATUS, 16'h3);
    wait_done;
  endtask
  task run_row(input pidc_row_t r);
    i_pidc_ctrl_prog.put_ops(r.sp, r.act, r.kp, r.tn, 16'h0, r.tc,
      {r.fl[2:1], 1'b0});
    reg_write(`PIDC_REG_CTRL, {15'h0, r.fl[0]});
    reg_write(`PIDC_REG_STATUS, 16'h3);
    i_pidc_ctrl_prog.put_mode(1'b1, 1'b0, 13'h0);
    wait_done;
    tick(1);
    chk_out(r.ex);
    chk_bit(range_exceeded, r.rg, "range flag");
    reg_read(`PIDC_REG_STATUS);
    chk_word({14'h0, r.rg, 1'b1});
    reg_read(`PIDC_REG_OUTPUT);
    chk_word({{3{r.ex[12]}}, r.ex});
    i_pidc_ctrl_prog.put_mode(1'b0, 1'b0, 13'h0);
    tick(2);
    chk_out(13'h0);
    chk_bit(range_exceeded, 1'b0, "flag after disable");
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    repeat (4) @(posedge core_clk);
    #1;
    chk_out(13'h0);
    chk_bit(irq, 1'b0, "irq in reset");
    @(posedge core_clk);
    rst_n <= 1'b1;
    reg_read(`PIDC_REG_MASK);
    chk_word(16'h0);
    reg_read(`PIDC_REG_CTRL);
    chk_word(16'h0);
    reg_read(4'h2);
    chk_word(16'h0);
    reg_write(`PIDC_REG_MASK, 16'h1);
    foreach (rows[i]) run_row(rows[i]);
    reg_write(`PIDC_REG_CTRL, 16'h0);
    // Operands must be in place before enable, or a stale scan runs first
    i_pidc_ctrl_prog.put_ops(16'h64, 16'h28, 16'h64, 16'h1E, 16'h1E, 16'h1E,
      3'h3);
    i_pidc_ctrl_prog.put_mode(1'b1, 1'b0, 13'h0);
    scan(16'h28, 16'h64);
    t0 = cyc;
    tick(1);
    chk_out(13'h3C);
    scan(16'hA, 16'h64);
    chk_bit(cyc - t0 == 300, 1'b1, "scan spacing");
    tick(1);
    chk_out(13'hB4);
    scan(16'hA, 16'h44C);
    tick(1);
    chk_out(13'h4D8);
    i_pidc_ctrl_prog.put_mode(1'b1, 1'b1, 13'h1FFB);
    tick(1);
    chk_out(13'h1FFB);
    i_pidc_ctrl_prog.put_mode(1'b1, 1'b1, 13'h123);
    tick(1);
    chk_out(13'h123);
    i_pidc_ctrl_prog.put_mode(1'b1, 1'b0, 13'h123);
    tick(1);
    chk_out(13'h4D8);
    reg_write(`PIDC_REG_STATUS, 16'h3);
    wait_done;
    tick(1);
    chk_out(13'h91A);
    reg_write(`PIDC_REG_MASK, 16'h0);
    chk_bit(irq, 1'b0, "masked irq");
    reg_write(`PIDC_REG_MASK, 16'h1);
    chk_bit(irq, 1'b1, "unmasked irq");
    reg_write(`PIDC_REG_STATUS, 16'h1);
    chk_bit(irq, 1'b0, "cleared irq");
    rst_n <= 1'b0;
    #1;
    chk_out(13'h0);
    @(posedge core_clk);
    rst_n <= 1'b1;
    reg_read(`PIDC_REG_MASK);
    chk_word(16'h0);
    close_out;
  end
endmodule // test_pidc_top
bind pidc_top pidc_chk i_pidc_chk (.core_clk, .rst_n, .master_enable,
  .manual_select, .manual_value, .reg_addr, .reg_rd, .reg_rdata,
  .control_output, .range_exceeded);
